//--- design/lcs_map.vh
// lcs_map.vh - offsets, field positions, reset values and timing counts
// of the load cell scan and setpoint controller.
// assumes: included by bare name from the design files; definitions only.
`ifndef LCS_MAP_VH
`define LCS_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets on the apb slave
// ----------------------------------------------------------------------
`define LCS_OFS_CHAN_EN     8'h00
`define LCS_OFS_OUT_MODE    8'h04
`define LCS_OFS_OUT_HOST    8'h08
`define LCS_OFS_IO_STATE    8'h0c
`define LCS_OFS_FILT_CFG    8'h10
`define LCS_OFS_SETPT_BASE  8'h20
`define LCS_OFS_WEIGHT_BASE 8'h30

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LCS_IO_IN_LSB       0
`define LCS_IO_OUT_LSB      4
`define LCS_ARRAY_SEL_LSB   4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LCS_RST_CHAN_EN     4'hf
`define LCS_RST_OUT_MODE    4'h0
`define LCS_RST_OUT_HOST    4'h0
`define LCS_RST_FILT_CFG    4'h0
`define LCS_RST_SETPT       24'h000000

// ----------------------------------------------------------------------
// timing: one conversion every 5000 us (200 hz) at a 100 mhz core clock
// ----------------------------------------------------------------------
`define LCS_CLK_MHZ         100
`define LCS_CONV_PERIOD_US  5000
`define LCS_CONV_CYC        20'd500000  // period in us times cycles per us, counter width

`endif

//--- design/lcs_chan.v
// lcs_chan.v - one measurement channel: conversion pacing, converter
// sample capture and the optional moving-average filter.
// assumes: converter pins are asynchronous to core_clk; rst is the
// controller's synchronous reset, active high, on core_clk.
`timescale 1ns/10ps
module lcs_chan #(
  parameter             DATA_W   = 24,
  parameter             AVG_LOG2 = 2,
  parameter             CNT_W    = 20,
  parameter [CNT_W-1:0] CONV_CYC = 20'd500000
) (
  input  wire              core_clk,    // core clock
  input  wire              rst,         // controller reset, active high
  input  wire              chan_en,     // channel is in the scan
  input  wire              filt_avg,    // 1: moving average, 0: raw
  input  wire              adc_drdy,    // converter data ready (pin)
  input  wire [DATA_W-1:0] adc_data,    // converter result (pins)
  input  wire              sample_ack,  // scheduler took the sample
  output reg               conv_start,  // one-cycle conversion start
  output reg               sample_rdy,  // fresh sample waiting
  output reg  [DATA_W-1:0] weight       // latest sample, signed
);

  localparam NAVG  = 1 << AVG_LOG2;
  localparam SUM_W = DATA_W + AVG_LOG2;

  reg                     drdy_s1_q;
  reg                     drdy_s2_q;
  reg                     drdy_s3_q;
  reg        [DATA_W-1:0] data_s1_q;
  reg        [DATA_W-1:0] data_s2_q;
  reg        [CNT_W-1:0]  cnt_q;
  reg        [DATA_W-1:0] hist_q [0:NAVG-1];
  reg        [AVG_LOG2-1:0] widx_q;
  reg signed [SUM_W-1:0]  sum_q;
  wire                    new_smp_w;
  wire signed [SUM_W-1:0] sum_d;
  integer                 i;

  // two-flop synchronisers on the converter pins
  always @(posedge core_clk) begin
    if (rst) begin
      drdy_s1_q <= 1'b0;
      drdy_s2_q <= 1'b0;
      drdy_s3_q <= 1'b0;
      data_s1_q <= {DATA_W{1'b0}};
      data_s2_q <= {DATA_W{1'b0}};
    end else begin
      drdy_s1_q <= adc_drdy;
      drdy_s2_q <= drdy_s1_q;
      drdy_s3_q <= drdy_s2_q;
      data_s1_q <= adc_data;
      data_s2_q <= data_s1_q;
    end
  end

  // a sample counts only while the channel is scanned
  assign new_smp_w = drdy_s2_q & ~drdy_s3_q & chan_en;

  // running sum: add the newest, drop the oldest of the window
  assign sum_d = sum_q + {{AVG_LOG2{data_s2_q[DATA_W-1]}}, data_s2_q}
                       - {{AVG_LOG2{hist_q[widx_q][DATA_W-1]}}, hist_q[widx_q]};

  // own pacing counter, free of the other channels, stopped when disabled
  always @(posedge core_clk) begin
    if (rst || !chan_en) begin
      cnt_q      <= {CNT_W{1'b0}};
      conv_start <= 1'b0;
    end else if (cnt_q == CONV_CYC - 1'b1) begin
      cnt_q      <= {CNT_W{1'b0}};
      conv_start <= 1'b1;
    end else begin
      cnt_q      <= cnt_q + 1'b1;
      conv_start <= 1'b0;
    end
  end

  // capture, filter and flag each new converter result
  always @(posedge core_clk) begin
    if (rst) begin
      for (i = 0; i < NAVG; i = i + 1) begin
        hist_q[i] <= {DATA_W{1'b0}};
      end
      widx_q     <= {AVG_LOG2{1'b0}};
      sum_q      <= {SUM_W{1'b0}};
      weight     <= {DATA_W{1'b0}};
      sample_rdy <= 1'b0;
    end else begin
      if (new_smp_w) begin
        hist_q[widx_q] <= data_s2_q;
        widx_q         <= widx_q + 1'b1;
        sum_q          <= sum_d;
        weight         <= filt_avg ? sum_d[SUM_W-1:AVG_LOG2] : data_s2_q;
      end
      // a new sample wins over the acknowledge of the old one
      if (new_smp_w) begin
        sample_rdy <= 1'b1;
      end else if (sample_ack) begin
        sample_rdy <= 1'b0;
      end
    end
  end

endmodule // lcs_chan

//--- design/lcs_top.v
// lcs_top.v - four-channel load cell scan and setpoint controller with
// its apb register slave and digital input/output pins.
// assumes: one 100 mhz core clock; rst_n is the power-up reset; the
// reset jumper pin and all converter and input pins are asynchronous.
//
// What this block does
// - The controller is held in reset while the reset jumper pin is high and restarts cleanly when it falls.
// - The controller resets itself at power-up.
// - The controller has no link to the host bus reset or the host's own reset and keeps running through them.
// - Each of the four channels takes samples from its own 24-bit converter followed by a filter.
// - Each converter is paced on its own and yields a fresh sample at a nominal 200 Hz.
// - The host loads each channel's filter setting, choosing raw samples or a moving average.
// - Tasks are serviced from a polling list and a started task finishes before the next begins.
// - The controller serves host accesses at its own address, samples the inputs and drives the outputs.
// - The host can read and write the channel enable bits and the output mode bits.
// - An enabled channel is scanned and measured, a disabled one is skipped and never measured.
// - With mode and enable both set, a channel's output follows the weight versus setpoint comparison.
// - With mode or enable clear, the host drives the channel's output directly.
// - A digital input reads as asserted when pulled to ground, so the pins are active low.
`timescale 1ns/10ps
`include "lcs_map.vh"
module lcs_top #(
  parameter NCH      = 4,
  parameter DATA_W   = 24,
  parameter AVG_LOG2 = 2,
  parameter CNT_W    = 20,
  parameter [CNT_W-1:0] CONV_CYC = `LCS_CONV_CYC
) (
  input  wire                  core_clk,          // core clock, 100 mhz
  input  wire                  rst_n,             // power-up reset, low
  input  wire                  ext_reset_jumper,  // external reset pin, high
  input  wire                  psel,              // apb select
  input  wire                  penable,           // apb access phase
  input  wire                  pwrite,            // apb write
  input  wire [7:0]            paddr,             // apb byte address
  input  wire [31:0]           pwdata,            // apb write data
  output reg  [31:0]           prdata,            // apb read data
  output reg                   pready,            // apb ready
  output reg                   pslverr,           // apb error, unmapped
  input  wire [NCH-1:0]        adc_drdy,          // converter ready pins
  input  wire [NCH*DATA_W-1:0] adc_data,          // converter data pins
  output wire [NCH-1:0]        conv_start,        // conversion start pulses
  input  wire [NCH-1:0]        din_n,             // digital inputs, low true
  output reg  [NCH-1:0]        dout               // 1: output conducting
);

  // --------------------------------------------------------------------
  // scheduler states, one hot
  // --------------------------------------------------------------------
  localparam [3:0] ST_CHAN  = 4'b0001;
  localparam [3:0] ST_BUS   = 4'b0010;
  localparam [3:0] ST_BWAIT = 4'b0100;
  localparam [3:0] ST_OUT   = 4'b1000;

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  reg                   xrst_s1_q;
  reg                   xrst_s2_q;
  reg  [NCH-1:0]        din_s1_q;
  reg  [NCH-1:0]        din_s2_q;
  reg  [3:0]            state_q;
  reg  [1:0]            ptr_q;
  reg  [NCH-1:0]        chan_en_q;
  reg  [NCH-1:0]        mode_q;
  reg  [NCH-1:0]        host_out_q;
  reg  [NCH-1:0]        filt_q;
  reg  [NCH-1:0]        ack_q;
  reg  [DATA_W-1:0]     setpt_q  [0:NCH-1];
  reg  [DATA_W-1:0]     weight_q [0:NCH-1];
  reg  [31:0]           rd_data_w;
  reg                   addr_ok_w;
  reg  [NCH-1:0]        cmp_w;
  wire                  ctl_rst_w;
  wire [NCH-1:0]        smp_rdy_w;
  wire [NCH*DATA_W-1:0] chan_wt_w;
  wire [NCH-1:0]        din_act_w;
  wire [1:0]            sel_w;
  wire                  is_setpt_w;
  wire                  is_weight_w;
  integer               k;
  integer               j;

  // --------------------------------------------------------------------
  // reset: power-up reset or held jumper; nothing from the host bus
  // --------------------------------------------------------------------

  // two-flop synchroniser on the reset jumper pin, cleared at power-up
  always @(posedge core_clk) begin
    if (!rst_n) begin
      xrst_s1_q <= 1'b0;
      xrst_s2_q <= 1'b0;
    end else begin
      xrst_s1_q <= ext_reset_jumper;
      xrst_s2_q <= xrst_s1_q;
    end
  end

  // the apb side brings no reset of its own into the controller
  assign ctl_rst_w = ~rst_n | xrst_s2_q;

  // --------------------------------------------------------------------
  // digital inputs
  // --------------------------------------------------------------------

  // two-flop synchroniser on the input pins
  always @(posedge core_clk) begin
    if (ctl_rst_w) begin
      din_s1_q <= {NCH{1'b1}};
      din_s2_q <= {NCH{1'b1}};
    end else begin
      din_s1_q <= din_n;
      din_s2_q <= din_s1_q;
    end
  end

  // pulled-up pins: a grounded pin is an asserted input
  assign din_act_w = ~din_s2_q;

  // --------------------------------------------------------------------
  // measurement channels
  // --------------------------------------------------------------------

  // one converter front end per channel, each paced on its own
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chan
      lcs_chan #(
        .DATA_W   (DATA_W),
        .AVG_LOG2 (AVG_LOG2),
        .CNT_W    (CNT_W),
        .CONV_CYC (CONV_CYC)
      ) u_chan (
        .core_clk   (core_clk),
        .rst        (ctl_rst_w),
        .chan_en    (chan_en_q[g]),
        .filt_avg   (filt_q[g]),
        .adc_drdy   (adc_drdy[g]),
        .adc_data   (adc_data[g*DATA_W +: DATA_W]),
        .sample_ack (ack_q[g]),
        .conv_start (conv_start[g]),
        .sample_rdy (smp_rdy_w[g]),
        .weight     (chan_wt_w[g*DATA_W +: DATA_W])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------

  // array registers: one word per channel, channel in address bits 3:2
  assign sel_w       = paddr[3:2];
  assign is_setpt_w  = ({paddr[7:4], 4'h0} == `LCS_OFS_SETPT_BASE)
                       && (paddr[1:0] == 2'b00);
  assign is_weight_w = ({paddr[7:4], 4'h0} == `LCS_OFS_WEIGHT_BASE)
                       && (paddr[1:0] == 2'b00);

  // read mux and address check; unused upper bits read as zero
  always @* begin
    rd_data_w = 32'h00000000;
    addr_ok_w = 1'b1;
    if (paddr == `LCS_OFS_CHAN_EN) begin
      rd_data_w[NCH-1:0] = chan_en_q;
    end else if (paddr == `LCS_OFS_OUT_MODE) begin
      rd_data_w[NCH-1:0] = mode_q;
    end else if (paddr == `LCS_OFS_OUT_HOST) begin
      rd_data_w[NCH-1:0] = host_out_q;
    end else if (paddr == `LCS_OFS_IO_STATE) begin
      rd_data_w[`LCS_IO_IN_LSB +: NCH]  = din_act_w;
      rd_data_w[`LCS_IO_OUT_LSB +: NCH] = dout;
    end else if (paddr == `LCS_OFS_FILT_CFG) begin
      rd_data_w[NCH-1:0] = filt_q;
    end else if (is_setpt_w) begin
      rd_data_w[DATA_W-1:0] = setpt_q[sel_w];
    end else if (is_weight_w) begin
      rd_data_w[DATA_W-1:0] = weight_q[sel_w];
    end else begin
      addr_ok_w = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // setpoint comparison, signed weights
  // --------------------------------------------------------------------

  // energise at or above the setpoint
  always @* begin
    for (j = 0; j < NCH; j = j + 1) begin
      cmp_w[j] = ($signed(weight_q[j]) >= $signed(setpt_q[j]));
    end
  end

  // --------------------------------------------------------------------
  // polling scheduler: channel, bus, outputs, round and round
  // --------------------------------------------------------------------

  // each state is one task that ends before the next is started;
  // a bus access waits for the bus slot, which bounds its latency
  always @(posedge core_clk) begin
    if (ctl_rst_w) begin
      state_q    <= ST_CHAN;
      ptr_q      <= 2'd0;
      ack_q      <= {NCH{1'b0}};
      chan_en_q  <= `LCS_RST_CHAN_EN;
      mode_q     <= `LCS_RST_OUT_MODE;
      host_out_q <= `LCS_RST_OUT_HOST;
      filt_q     <= `LCS_RST_FILT_CFG;
      dout       <= {NCH{1'b0}};
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        setpt_q[k]  <= `LCS_RST_SETPT;
        weight_q[k] <= {DATA_W{1'b0}};
      end
    end else begin
      ack_q <= {NCH{1'b0}};
      case (state_q)
        // take one waiting sample from the channel under the pointer
        ST_CHAN: begin
          if (chan_en_q[ptr_q] && smp_rdy_w[ptr_q]) begin
            weight_q[ptr_q] <= chan_wt_w[ptr_q*DATA_W +: DATA_W];
            ack_q[ptr_q]    <= 1'b1;
          end
          ptr_q   <= ptr_q + 2'd1;
          state_q <= ST_BUS;
        end
        // accept an apb access phase, present the read answer
        ST_BUS: begin
          if (psel && penable) begin
            pready  <= 1'b1;
            pslverr <= ~addr_ok_w;
            prdata  <= (pwrite || !addr_ok_w) ? 32'h00000000 : rd_data_w;
            state_q <= ST_BWAIT;
          end else begin
            state_q <= ST_OUT;
          end
        end
        // the edge with pready high completes the transfer
        ST_BWAIT: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (pwrite && addr_ok_w) begin
            if (paddr == `LCS_OFS_CHAN_EN) begin
              chan_en_q <= pwdata[NCH-1:0];
            end else if (paddr == `LCS_OFS_OUT_MODE) begin
              mode_q <= pwdata[NCH-1:0];
            end else if (paddr == `LCS_OFS_OUT_HOST) begin
              host_out_q <= pwdata[NCH-1:0];
            end else if (paddr == `LCS_OFS_FILT_CFG) begin
              filt_q <= pwdata[NCH-1:0];
            end else if (is_setpt_w) begin
              setpt_q[sel_w] <= pwdata[DATA_W-1:0];
            end
          end
          state_q <= ST_OUT;
        end
        // refresh every output: comparison or host control per channel
        ST_OUT: begin
          for (k = 0; k < NCH; k = k + 1) begin
            if (mode_q[k] && chan_en_q[k]) begin
              dout[k] <= cmp_w[k];
            end else begin
              dout[k] <= host_out_q[k];
            end
          end
          state_q <= ST_CHAN;
        end
        default: begin
          state_q <= ST_CHAN;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

endmodule // lcs_top

//--- sim/lcs_props.sv
// lcs_props.sv - port assertions for the load cell scan controller top.
// assumes: bound into lcs_top by the bind at the foot of this file.
`timescale 1ns/10ps
`include "lcs_map.vh"
module lcs_props #(
  parameter int CONV_CYC = 50
) (
  input logic       core_clk,          // core clock
  input logic       rst_n,             // power-up reset, low
  input logic       ext_reset_jumper,  // external reset pin
  input logic       psel,              // apb select
  input logic       penable,           // apb access phase
  input logic       pwrite,            // apb write
  input logic [7:0] paddr,             // apb address
  input logic [31:0] pwdata,           // apb write data
  input logic       pready,            // apb ready
  input logic       pslverr,           // apb error
  input logic [3:0] conv_start,        // conversion starts
  input logic [3:0] dout               // digital outputs
);
  // ------------------------------------------------------------------
  // shadow control bits and counters
  // ------------------------------------------------------------------
  logic [3:0]  en_q, mode_q, host_q, quiet_q;
  logic [31:0] gap_q;
  logic        seen_q;
  wire         wr = psel && penable && pready && pwrite;
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && (a <= 8'h10 || (a >= 8'h20 && a <= 8'h3c));
  endfunction
  // copies of enable, mode and host output bits, plus quiet time since a write
  always_ff @(posedge core_clk) begin
    if (!rst_n || ext_reset_jumper) begin
      en_q <= `LCS_RST_CHAN_EN;
      mode_q <= `LCS_RST_OUT_MODE;
      host_q <= `LCS_RST_OUT_HOST;
      quiet_q <= 4'h0;
    end else begin
      quiet_q <= wr ? 4'h0 : (quiet_q == 4'h8 ? quiet_q : quiet_q + 4'h1);
      if (wr && paddr == `LCS_OFS_CHAN_EN) en_q <= pwdata[3:0];
      if (wr && paddr == `LCS_OFS_OUT_MODE) mode_q <= pwdata[3:0];
      if (wr && paddr == `LCS_OFS_OUT_HOST) host_q <= pwdata[3:0];
    end
  end
  // cycles since the last conversion start of channel 0
  always_ff @(posedge core_clk) begin
    if (!rst_n || ext_reset_jumper || !en_q[0]) begin
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else if (conv_start[0]) begin
      gap_q <= 32'h0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  property p_rst_clear;
    @(posedge core_clk) !rst_n |=> !pready && !pslverr && dout == 4'h0 && conv_start == 4'h0;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs busy after reset");
  property p_jmp_clear;
    @(posedge core_clk) disable iff (!rst_n)
      ext_reset_jumper [*3] |=> !pready && dout == 4'h0 && conv_start == 4'h0;
  endproperty
  a_jmp_clear: assert property (p_jmp_clear) else $error("jumper did not hold reset");
  property p_done_pulse;
    @(posedge core_clk) disable iff (!rst_n) pready |=> !pready;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("ready longer than one cycle");
  property p_done_cause;
    @(posedge core_clk) disable iff (!rst_n) pready |-> psel && penable;
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("ready without access");
  property p_latency;
    @(posedge core_clk) disable iff (!rst_n) $rose(penable) && psel |-> ##[1:4] pready;
  endproperty
  a_latency: assert property (p_latency) else $error("access not served in time");
  property p_err_map;
    @(posedge core_clk) disable iff (!rst_n) pslverr == (pready && !mapped(paddr));
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
  property p_skip_off;
    @(posedge core_clk) disable iff (!rst_n) (conv_start & ~en_q & ~$past(en_q)) == 4'h0;
  endproperty
  a_skip_off: assert property (p_skip_off) else $error("disabled channel converted");
  property p_conv_gap;
    @(posedge core_clk) disable iff (!rst_n) conv_start[0] && seen_q |-> gap_q == CONV_CYC - 1;
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("conversion period wrong");
  property p_conv_late;
    @(posedge core_clk) disable iff (!rst_n) seen_q |-> gap_q < CONV_CYC;
  endproperty
  a_conv_late: assert property (p_conv_late) else $error("conversion start missing");
  property p_host_out;
    @(posedge core_clk) disable iff (!rst_n)
      quiet_q == 4'h8 |-> ((dout ^ host_q) & ~(mode_q & en_q)) == 4'h0;
  endproperty
  a_host_out: assert property (p_host_out) else $error("host output not followed");
  c_err: cover property (@(posedge core_clk) pslverr);
  c_cmp: cover property (@(posedge core_clk) dout[0] && mode_q[0] && !host_q[0]);
  c_conv: cover property (@(posedge core_clk) conv_start[3] && seen_q);
endmodule // lcs_props

bind lcs_top lcs_props #(.CONV_CYC(CONV_CYC)) u_props (.*);

//--- sim/lcs_adc_model.sv
// lcs_adc_model.sv - four converters answering conversion starts.
// assumes: value holds the sample each channel should report.
`timescale 1ns/10ps
module lcs_adc_model (
  input  logic        core_clk,    // core clock
  input  logic [3:0]  conv_start,  // start pulses from the block
  input  logic [95:0] value,       // samples to report
  output logic [3:0]  adc_drdy,    // data ready pins
  output logic [95:0] adc_data     // data pins
);
  // ------------------------------------------------------------------
  // per-channel converter, prompt and slow in turn
  // ------------------------------------------------------------------
  genvar k;
  for (k = 0; k < 4; k++) begin : g_ch
    logic [3:0] cnt_q = 4'h0;
    logic       slow_q = 1'b0;
    // count down from the start; ready window is the last six counts
    always @(posedge core_clk) begin
      if (conv_start[k]) begin
        cnt_q <= slow_q ? 4'he : 4'h8;
        slow_q <= ~slow_q;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
    assign adc_drdy[k] = cnt_q != 4'h0 && cnt_q <= 4'h6;
    // outside the window the bus shows the inverse, never the held value
    assign adc_data[24*k+:24] = adc_drdy[k] ? value[24*k+:24] : ~value[24*k+:24];
  end
endmodule // lcs_adc_model

//--- sim/lcs_tb_top.sv
// lcs_tb_top.sv - self-checking bench for the scan controller top.
// assumes: lcs_props bound in; converter model on the far side.
`timescale 1ns/10ps
`include "lcs_map.vh"
module lcs_tb_top;
  localparam int CC = 50;
  logic        core_clk = 0, rst_n = 0, ext_reset_jumper = 0;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, s = 32'h9;
  logic [3:0]  adc_drdy, conv_start, dout, din_n = 4'hf, hv = 4'h0;
  logic [95:0] adc_data, adc_val = 96'h0;
  logic [23:0] sp;
  int          err_total = 0, num_checks = 0;
  // ------------------------------------------------------------------
  // clock, design and converter model
  // ------------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  lcs_top #(.CONV_CYC(20'd50)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .ext_reset_jumper(ext_reset_jumper), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_drdy(adc_drdy), .adc_data(adc_data), .conv_start(conv_start), .din_n(din_n),
    .dout(dout));
  lcs_adc_model u_adc (.core_clk(core_clk), .conv_start(conv_start), .value(adc_val),
    .adc_drdy(adc_drdy), .adc_data(adc_data));
  function logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // expected outputs: compare mode when mode and enable set, else host bit
  function logic [3:0] exp_out(input logic [3:0] m, e, h, input logic [95:0] w);
    for (int k = 0; k < 4; k++)
      exp_out[k] = (m[k] & e[k]) ? $signed(w[24*k+:24]) >= $signed(sp) : h[k];
  endfunction
  task chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      err_total++;
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task chk_weights();
    for (int k = 0; k < 4; k++) begin
      apb(0, `LCS_OFS_WEIGHT_BASE + 8'(4 * k), 0);
      chk("weight", {8'h00, adc_val[24*k+:24]}, rd);
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    $display("MISMATCH watchdog expected done seen timeout");
    err_total++;
    summarize();
  end
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    wt(20);
    rst_n <= 1;
    apb(0, `LCS_OFS_CHAN_EN, 0);
    chk("enable reset", 32'h0000000f, rd);
    apb(0, `LCS_OFS_FILT_CFG, 0);
    chk("filter reset", 32'h0, rd);
    apb(0, 8'h14, 0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1, `LCS_OFS_WEIGHT_BASE, 32'h123);
    apb(0, `LCS_OFS_WEIGHT_BASE, 0);
    chk("weight read only", 32'h0, rd);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      rd = rnd();
      din_n <= rd[3:0];
      hv = rd[7:4];
      apb(1, `LCS_OFS_OUT_HOST, {28'h0, hv});
      wt(12);
      chk("host outputs", exp_out(4'h0, 4'hf, hv, adc_val), dout);
      apb(0, `LCS_OFS_IO_STATE, 0);
      chk("io state", {24'h0, hv, ~din_n}, rd);
    end
    $display("test host outputs done");
    rd = rnd();
    sp = {2'b00, rd[21:0]};
    adc_val = {sp + 24'd5, 24'hffffff, sp - 24'd1, sp};
    for (int k = 0; k < 4; k++) apb(1, `LCS_OFS_SETPT_BASE + 8'(4 * k), {8'h0, sp});
    apb(1, `LCS_OFS_OUT_MODE, 32'hf);
    wt(3 * CC + 40);
    chk("compare outputs", exp_out(4'hf, 4'hf, hv, adc_val), dout);
    chk_weights();
    $display("test setpoint compare done");
    apb(1, `LCS_OFS_CHAN_EN, 32'he);
    wt(10);
    adc_val[23:0] = sp + 24'd100;
    wt(3 * CC);
    apb(0, `LCS_OFS_WEIGHT_BASE, 0);
    chk("skipped weight", {8'h0, sp}, rd);
    chk("disabled outputs", exp_out(4'hf, 4'he, hv, adc_val), dout);
    apb(1, `LCS_OFS_CHAN_EN, 32'hf);
    wt(3 * CC + 40);
    chk_weights();
    $display("test channel enable done");
    apb(1, `LCS_OFS_FILT_CFG, 32'hf);
    wt(6 * CC + 40);
    chk_weights();
    $display("test filter done");
    apb(1, `LCS_OFS_CHAN_EN, 32'h0);
    apb(1, `LCS_OFS_OUT_MODE, 32'h5);
    ext_reset_jumper <= 1;
    wt(5);
    ext_reset_jumper <= 0;
    wt(4);
    apb(0, `LCS_OFS_CHAN_EN, 0);
    chk("enable after jumper", 32'hf, rd);
    apb(0, `LCS_OFS_OUT_MODE, 0);
    chk("mode after jumper", 32'h0, rd);
    $display("test jumper reset done");
    for (int i = 0; i < 8; i++) begin
      s = rnd();
      apb(1, `LCS_OFS_SETPT_BASE + 8'(4 * (i % 4)), s);
      apb(0, `LCS_OFS_SETPT_BASE + 8'(4 * (i % 4)), 0);
      chk("setpoint", {8'h0, s[23:0]}, rd);
    end
    $display("test setpoint access done");
    summarize();
  end
endmodule // lcs_tb_top
